/* bsf_defines.svh */
`ifndef BSF_DEFINES_SVH
`define BSF_DEFINES_SVH

// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define BSF_REG_CTRL 8'h00
`define BSF_REG_ADDR 8'h04
`define BSF_REG_WDATA 8'h08
`define BSF_REG_STATUS 8'h0C
`define BSF_REG_RDATA 8'h10
`define BSF_CTRL_RST 32'h0000_0000
`define BSF_ADDR_RST 19'h0_0000
`define BSF_WDATA_RST 16'h0000

// ----------------------------------------
// field positions
// ----------------------------------------
`define BSF_CTRL_CMD_LSB 0
`define BSF_CTRL_CMD_MSB 3
`define BSF_CTRL_GO 4
`define BSF_CTRL_BYTE 8
`define BSF_CTRL_STBY 9
`define BSF_CTRL_HWRST 10
`define BSF_STAT_BUSY 0
`define BSF_STAT_BYPASS 1
`define BSF_STAT_READY 2
`define BSF_STAT_POLL 3
`define BSF_TOGGLE_BIT 6

// ----------------------------------------
// timing
// ----------------------------------------
`define BSF_CLK_NS 50
`define BSF_T_ACC_NS 90
`define BSF_T_WP_NS 35
`define BSF_T_RP_NS 500
`define BSF_SYNC_CYC 3
`define BSF_ACC_CYC ((`BSF_T_ACC_NS + `BSF_CLK_NS - 1) / `BSF_CLK_NS)
`define BSF_WP_CYC ((`BSF_T_WP_NS + `BSF_CLK_NS - 1) / `BSF_CLK_NS)
`define BSF_RP_CYC ((`BSF_T_RP_NS + `BSF_CLK_NS - 1) / `BSF_CLK_NS)

// ----------------------------------------
// command cycle codes
// ----------------------------------------
`define BSF_UNLK1_ADDR_W 19'h0_0555
`define BSF_UNLK2_ADDR_W 19'h0_02AA
`define BSF_UNLK1_ADDR_B 19'h0_0AAA
`define BSF_UNLK2_ADDR_B 19'h0_0555
`define BSF_UNLK1_DATA 16'h00AA
`define BSF_UNLK2_DATA 16'h0055
`define BSF_CODE_PROG 16'h00A0
`define BSF_CODE_ERASE 16'h0080
`define BSF_CODE_CHIP 16'h0010
`define BSF_CODE_SECT 16'h0030
`define BSF_CODE_SUSP 16'h00B0
`define BSF_CODE_RESUME 16'h0030
`define BSF_CODE_RESET 16'h00F0
`define BSF_CODE_BYP 16'h0020
`define BSF_CODE_BYPX1 16'h0090
`define BSF_CODE_BYPX2 16'h0000

`endif

/* bsf_pkg.sv */
`default_nettype none
package bsf_pkg;
	typedef enum logic [3:0] {
		BSF_CMD_READ = 4'h0,
		BSF_CMD_PROG = 4'h1,
		BSF_CMD_CHIP = 4'h2,
		BSF_CMD_SECT = 4'h3,
		BSF_CMD_SUSP = 4'h4,
		BSF_CMD_RESUME = 4'h5,
		BSF_CMD_RESET = 4'h6,
		BSF_CMD_BYP_ENTER = 4'h7,
		BSF_CMD_BYP_EXIT = 4'h8
	} bsf_cmd_t;
	typedef enum logic [2:0] {
		BSF_S_IDLE = 3'b000,
		BSF_S_WSET = 3'b001,
		BSF_S_WPUL = 3'b010,
		BSF_S_WREC = 3'b011,
		BSF_S_RSET = 3'b100,
		BSF_S_RCAP = 3'b101,
		BSF_S_RGAP = 3'b110,
		BSF_S_RST = 3'b111
	} bsf_state_t;
	typedef struct packed {
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic rst_n;
		logic byte_n;
		logic [17:0] addr;
		logic [15:0] data_lines_o;
		logic [15:0] data_lines_oe;
	} bsf_pins_t;
	typedef struct packed {
		logic [18:0] addr;
		logic [15:0] data;
	} bsf_cycle_t;
endpackage : bsf_pkg
`default_nettype wire

/* bsf_host_ctrl.sv */
// What this block does
// - never drive data while output enabled
// - commands issued as plain write cycles
// - bypass program takes two writes
// - completion detected by toggle bit polling
// - suspend and resume erase on command
// - standby by holding chip select high
// - width select pin picks byte or word
// - top data line is low address in byte mode
`timescale 1ns/10ps
`default_nettype none
`include "bsf_defines.svh"
module bsf_host_ctrl
	import bsf_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output var bsf_pins_t flash_pins,
	input wire logic [15:0] data_lines_i,
	input wire logic ready_busy_n
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == `BSF_REG_CTRL) || (a == `BSF_REG_ADDR) || (a == `BSF_REG_WDATA) ||
			(a == `BSF_REG_STATUS) || (a == `BSF_REG_RDATA);
	endfunction : mapped

	function automatic logic [31:0] lane_mask(input logic [3:0] strb);
		lane_mask = 32'h0000_0000;
		for (int i = 0; i < 4; i++) begin
			lane_mask[i*8 +: 8] = {8{strb[i]}};
		end
	endfunction : lane_mask

	function automatic logic [2:0] seq_len(input bsf_cmd_t c, input logic byp);
		unique case (c)
			BSF_CMD_READ: seq_len = 3'd0;
			BSF_CMD_PROG: seq_len = byp ? 3'd2 : 3'd4;
			BSF_CMD_CHIP, BSF_CMD_SECT: seq_len = 3'd6;
			BSF_CMD_BYP_ENTER: seq_len = 3'd3;
			BSF_CMD_BYP_EXIT: seq_len = 3'd2;
			default: seq_len = 3'd1;
		endcase
	endfunction : seq_len

	function automatic bsf_cycle_t seq_cycle(input bsf_cmd_t c, input logic [2:0] step,
		input logic byp, input logic bm, input logic [18:0] a, input logic [15:0] d);
		bsf_cycle_t r;
		logic [18:0] u1a;
		logic [18:0] u2a;
		u1a = bm ? `BSF_UNLK1_ADDR_B : `BSF_UNLK1_ADDR_W;
		u2a = bm ? `BSF_UNLK2_ADDR_B : `BSF_UNLK2_ADDR_W;
		r.addr = a;
		r.data = d;
		if (c == BSF_CMD_SUSP) r.data = `BSF_CODE_SUSP;
		else if (c == BSF_CMD_RESUME) r.data = `BSF_CODE_RESUME;
		else if (c == BSF_CMD_RESET) r.data = `BSF_CODE_RESET;
		else if (c == BSF_CMD_BYP_EXIT) r.data = (step == 3'd0) ? `BSF_CODE_BYPX1 : `BSF_CODE_BYPX2;
		else if (c == BSF_CMD_PROG && (byp ? step != 3'd0 : step == 3'd3)) r.data = d;
		else if (c == BSF_CMD_PROG && byp) r.data = `BSF_CODE_PROG;
		else begin
			case (step)
				3'd0, 3'd3: begin
					r.addr = u1a;
					r.data = `BSF_UNLK1_DATA;
				end
				3'd1, 3'd4: begin
					r.addr = u2a;
					r.data = `BSF_UNLK2_DATA;
				end
				3'd2: begin
					r.addr = u1a;
					r.data = (c == BSF_CMD_PROG) ? `BSF_CODE_PROG :
						(c == BSF_CMD_BYP_ENTER) ? `BSF_CODE_BYP : `BSF_CODE_ERASE;
				end
				default: begin
					r.addr = (c == BSF_CMD_CHIP) ? u1a : a;
					r.data = (c == BSF_CMD_CHIP) ? `BSF_CODE_CHIP : `BSF_CODE_SECT;
				end
			endcase
		end
		seq_cycle = r;
	endfunction : seq_cycle

	// byte mode: pins carry a[18:1], top data line carries a[0]
	function automatic bsf_pins_t drive(input bsf_pins_t p, input logic bm,
		input bsf_cycle_t cy, input logic wr);
		bsf_pins_t q;
		q = p;
		q.byte_n = ~bm;
		q.addr = bm ? cy.addr[18:1] : cy.addr[17:0];
		if (bm) begin
			q.data_lines_o = {cy.addr[0], 7'h00, cy.data[7:0]};
			q.data_lines_oe = wr ? 16'h80FF : 16'h8000;
		end else begin
			q.data_lines_o = cy.data;
			q.data_lines_oe = wr ? 16'hFFFF : 16'h0000;
		end
		drive = q;
	endfunction : drive

	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic [31:0] ctrl_r;
	logic [18:0] addr_r;
	logic [15:0] wdat_r;
	logic [15:0] rd_r;
	logic rb_ready_r;
	bsf_state_t state_r;
	logic poll_r;
	logic bypass_r;
	logic wr_fire;
	logic [31:0] wmask;
	logic go;
	logic hwrst_go;

	assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	assign wmask = lane_mask(wstrb_r) & {32{wr_fire && awaddr_r == `BSF_REG_CTRL}};
	assign go = wmask[`BSF_CTRL_GO] && wdata_r[`BSF_CTRL_GO];
	assign hwrst_go = wmask[`BSF_CTRL_HWRST] && wdata_r[`BSF_CTRL_HWRST];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_r <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= mapped(awaddr_r) ? 2'h0 : 2'h2;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= `BSF_CTRL_RST;
			addr_r <= `BSF_ADDR_RST;
			wdat_r <= `BSF_WDATA_RST;
		end else if (ce && wr_fire) begin
			// go and reset bits are pulses, never stored
			ctrl_r <= ((ctrl_r & ~wmask) | (wdata_r & wmask)) & 32'h0000_030F;
			if (awaddr_r == `BSF_REG_ADDR) begin
				addr_r <= 19'((addr_r & ~lane_mask(wstrb_r)) | (wdata_r & lane_mask(wstrb_r)));
			end
			if (awaddr_r == `BSF_REG_WDATA) begin
				wdat_r <= 16'((wdat_r & ~lane_mask(wstrb_r)) | (wdata_r & lane_mask(wstrb_r)));
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'h0;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= mapped(s_axi_araddr) ? 2'h0 : 2'h2;
				unique case (s_axi_araddr)
					`BSF_REG_CTRL: s_axi_rdata <= ctrl_r;
					`BSF_REG_ADDR: s_axi_rdata <= {13'h0000, addr_r};
					`BSF_REG_WDATA: s_axi_rdata <= {16'h0000, wdat_r};
					`BSF_REG_STATUS: s_axi_rdata <= {28'h000_0000, poll_r, rb_ready_r,
						bypass_r, state_r != BSF_S_IDLE};
					`BSF_REG_RDATA: s_axi_rdata <= {16'h0000, rd_r};
					default: s_axi_rdata <= 32'h0000_0000;
				endcase
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// pin input synchronisers
	// ----------------------------------------
	logic [15:0] din_s1, din_s2, din_s3;
	logic rb_s1, rb_s2, rb_s3;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			din_s1 <= 16'hFFFF;
			din_s2 <= 16'hFFFF;
			din_s3 <= 16'hFFFF;
			rb_s1 <= 1'b1;
			rb_s2 <= 1'b1;
			rb_s3 <= 1'b1;
			rb_ready_r <= 1'b1;
		end else if (ce) begin
			din_s1 <= data_lines_i;
			din_s2 <= din_s1;
			din_s3 <= din_s2;
			rb_s1 <= ready_busy_n;
			rb_s2 <= rb_s1;
			rb_s3 <= rb_s2;
			if (rb_s2 == rb_s3) rb_ready_r <= rb_s3;
		end
	end

	// ----------------------------------------
	// pin sequencer
	// ----------------------------------------
	bsf_cmd_t cmd_r;
	logic [2:0] step_r;
	logic [3:0] cnt_r;
	logic first_r;
	logic prev_tog_r;
	logic susp_req_r;
	logic bm;
	bsf_cycle_t cyc;

	assign bm = ctrl_r[`BSF_CTRL_BYTE];
	assign cyc = seq_cycle(cmd_r, step_r, bypass_r, bm, addr_r, wdat_r);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= BSF_S_IDLE;
			cmd_r <= BSF_CMD_READ;
			step_r <= 3'd0;
			cnt_r <= 4'h0;
			poll_r <= 1'b0;
			first_r <= 1'b0;
			prev_tog_r <= 1'b0;
			bypass_r <= 1'b0;
			susp_req_r <= 1'b0;
			rd_r <= 16'hFFFF;
			flash_pins <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rst_n: 1'b1, byte_n: 1'b1,
				addr: 18'h0_0000, data_lines_o: 16'h0000, data_lines_oe: 16'h0000};
		end else if (ce) begin
			// reset pulse wins in every state
			if (hwrst_go) begin
				state_r <= BSF_S_RST;
				cnt_r <= 4'h0;
				flash_pins.rst_n <= 1'b0;
				flash_pins.ce_n <= 1'b1;
				flash_pins.oe_n <= 1'b1;
				flash_pins.we_n <= 1'b1;
				flash_pins.data_lines_oe <= 16'h0000;
			end else begin
				// suspend may cut into a running poll
				if (go && poll_r && bsf_cmd_t'((ctrl_r[3:0] & ~wmask[3:0]) |
					(wdata_r[3:0] & wmask[3:0])) == BSF_CMD_SUSP) susp_req_r <= 1'b1;
				unique case (state_r)
					BSF_S_IDLE: begin
						flash_pins.ce_n <= ctrl_r[`BSF_CTRL_STBY];
						flash_pins.byte_n <= ~bm;
						// low address line held in byte mode
						flash_pins.data_lines_oe <= bm ? 16'h8000 : 16'h0000;
						if (go) begin
							cmd_r <= bsf_cmd_t'(wdata_r[`BSF_CTRL_CMD_MSB:`BSF_CTRL_CMD_LSB]);
							step_r <= 3'd0;
							cnt_r <= 4'h0;
							state_r <= (wdata_r[3:0] == 4'h0) ? BSF_S_RSET : BSF_S_WSET;
						end
					end
					BSF_S_WSET: begin
						// set address and data with strobe high
						flash_pins <= drive(flash_pins, bm, cyc, 1'b1);
						flash_pins.ce_n <= 1'b0;
						flash_pins.oe_n <= 1'b1;
						state_r <= BSF_S_WPUL;
					end
					BSF_S_WPUL: begin
						flash_pins.we_n <= 1'b0;
						cnt_r <= cnt_r + 4'h1;
						if (cnt_r == 4'(`BSF_WP_CYC)) begin
							flash_pins.we_n <= 1'b1;
							state_r <= BSF_S_WREC;
						end
					end
					BSF_S_WREC: begin
						cnt_r <= 4'h0;
						step_r <= step_r + 3'd1;
						state_r <= BSF_S_WSET;
						if (step_r == seq_len(cmd_r, bypass_r) - 3'd1) begin
							if (cmd_r == BSF_CMD_BYP_ENTER) bypass_r <= 1'b1;
							if (cmd_r == BSF_CMD_BYP_EXIT || cmd_r == BSF_CMD_RESET) bypass_r <= 1'b0;
							// embedded run is awaited by polling
							poll_r <= cmd_r inside {BSF_CMD_PROG, BSF_CMD_CHIP, BSF_CMD_SECT,
								BSF_CMD_SUSP};
							first_r <= 1'b1;
							state_r <= BSF_S_RGAP;
						end
					end
					BSF_S_RSET: begin
						// drop data drive as output enable falls
						flash_pins <= drive(flash_pins, bm, '{addr: addr_r, data: 16'h0000}, 1'b0);
						flash_pins.ce_n <= 1'b0;
						flash_pins.oe_n <= 1'b0;
						cnt_r <= cnt_r + 4'h1;
						if (cnt_r == 4'(`BSF_ACC_CYC + `BSF_SYNC_CYC)) state_r <= BSF_S_RCAP;
					end
					BSF_S_RCAP: begin
						if (din_s2 == din_s3) begin
							// byte mode keeps only low lines
							rd_r <= bm ? {8'h00, din_s3[7:0]} : din_s3;
							// done once toggle bit holds still
							if (poll_r && !first_r && din_s3[`BSF_TOGGLE_BIT] == prev_tog_r) begin
								poll_r <= 1'b0;
							end
							prev_tog_r <= din_s3[`BSF_TOGGLE_BIT];
							first_r <= 1'b0;
							flash_pins.oe_n <= 1'b1;
							state_r <= BSF_S_RGAP;
						end
					end
					BSF_S_RGAP: begin
						// toggle bit only moves between separate reads
						flash_pins.oe_n <= 1'b1;
						flash_pins.data_lines_oe <= bm ? 16'h8000 : 16'h0000;
						cnt_r <= 4'h0;
						if (susp_req_r) begin
							susp_req_r <= 1'b0;
							cmd_r <= BSF_CMD_SUSP;
							step_r <= 3'd0;
							poll_r <= 1'b0;
							state_r <= BSF_S_WSET;
						end else begin
							state_r <= poll_r ? BSF_S_RSET : BSF_S_IDLE;
						end
					end
					BSF_S_RST: begin
						cnt_r <= cnt_r + 4'h1;
						if (cnt_r == 4'(`BSF_RP_CYC)) begin
							flash_pins.rst_n <= 1'b1;
							bypass_r <= 1'b0;
							poll_r <= 1'b0;
							susp_req_r <= 1'b0;
							state_r <= BSF_S_IDLE;
						end
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_no_contend;
		!flash_pins.oe_n |-> flash_pins.data_lines_oe[14:0] == 15'h0000;
	endproperty
	a_no_contend: assert property (p_no_contend) else $error("data driven during read");

	property p_we_needs_ce;
		!flash_pins.we_n |-> !flash_pins.ce_n && flash_pins.oe_n && flash_pins.data_lines_oe[0];
	endproperty
	a_we_needs_ce: assert property (p_we_needs_ce) else $error("write strobe malformed");

	property p_byte_lines;
		!flash_pins.byte_n && !flash_pins.ce_n |-> flash_pins.data_lines_oe[14:8] == 7'h00;
	endproperty
	a_byte_lines: assert property (p_byte_lines) else $error("upper lines driven in byte mode");

	property p_low_addr;
		!flash_pins.byte_n && !flash_pins.ce_n |-> flash_pins.data_lines_oe[15];
	endproperty
	a_low_addr: assert property (p_low_addr) else $error("low address not driven");

	property p_standby;
		state_r == BSF_S_IDLE && $past(state_r) == BSF_S_IDLE && $past(ctrl_r[`BSF_CTRL_STBY])
			&& $past(ce) |-> flash_pins.ce_n;
	endproperty
	a_standby: assert property (p_standby) else $error("standby without chip select high");

	property p_hwrst;
		hwrst_go && ce |=> !flash_pins.rst_n && state_r == BSF_S_RST;
	endproperty
	a_hwrst: assert property (p_hwrst) else $error("reset pin not asserted");

	property p_bypass_len;
		state_r == BSF_S_WREC && cmd_r == BSF_CMD_PROG && bypass_r |-> step_r <= 3'd1;
	endproperty
	a_bypass_len: assert property (p_bypass_len) else $error("bypass program too long");

	property p_poll_done;
		ce && state_r == BSF_S_RCAP && poll_r && !first_r && din_s2 == din_s3 &&
			din_s3[`BSF_TOGGLE_BIT] == prev_tog_r |=> !poll_r ##1
			state_r inside {BSF_S_IDLE, BSF_S_WSET} || !ce;
	endproperty
	a_poll_done: assert property (p_poll_done) else $error("poll did not finish");

	property p_bresp_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bresp_hold: assert property (p_bresp_hold) else $error("write response dropped");
endmodule : bsf_host_ctrl
`default_nettype wire

/* bsf_flash_model.sv */
`timescale 1ns/10ps
`default_nettype none
module bsf_flash_model
	import bsf_pkg::*;
#(
	parameter int PROT_SECT = 6,
	parameter int PROG_NS = 2000,
	parameter int ERASE_NS = 6000
) (
	input var bsf_pins_t pins,
	input wire logic [15:0] bus,
	output logic [15:0] dev_q,
	output logic ready_busy_n,
	output var int n_wr
);
	// ----------------------------------------
	// array and state
	// ----------------------------------------
	logic [15:0] mem [0:127];
	logic [15:0] val, lastv;
	int left, pleft;
	logic pend, byp, susp, tg, last90;
	// top address bits pick the sector
	wire logic [6:0] ix = {pins.addr[17:15], pins.addr[3:0]};
	wire logic drv = !pins.ce_n && !pins.oe_n;
	wire logic busy = pleft > 0 || (left > 0 && !susp);
	initial begin
		foreach (mem[i]) mem[i] = 16'hFFFF;
		{pend, byp, susp, tg, last90} = 5'h00;
		left = 0;
		pleft = 0;
		n_wr = 0;
		lastv = 16'h0000;
	end
	// erase skips unselected and locked sectors
	task automatic erase(input logic chip);
		foreach (mem[i])
			if (i[6:4] != PROT_SECT && (chip || i[6:4] == ix[6:4]))
				mem[i] = 16'hFFFF;
		left = ERASE_NS / 50;
	endtask : erase
	// ----------------------------------------
	// command cycles, latched on the strobe's rise
	// ----------------------------------------
	// command decode
	always @(posedge pins.we_n) begin
		if (!pins.ce_n && pins.rst_n) begin
			n_wr++;
			if (pend) begin
				if (ix[6:4] != PROT_SECT) mem[ix] &= bus;
				pend = 1'b0;
				pleft = PROG_NS / 50;
			end else case (bus[7:0])
				8'hA0: pend = 1'b1;
				8'h10: erase(1'b1);
				8'h30: if (susp) susp = 1'b0; else erase(1'b0);
				8'hB0: susp = left > 0;
				8'hF0: pend = 1'b0;
				8'h20: byp = 1'b1;
				8'h00: if (last90) byp = 1'b0;
				default: ;
			endcase
			last90 = bus[7:0] == 8'h90;
		end
	end
	always #50 begin
		if (pleft > 0) pleft--;
		else if (left > 0 && !susp) left--;
	end
	always @(negedge pins.rst_n) begin
		left = 0;
		pleft = 0;
		{pend, byp, susp} = 3'b000;
	end
	// status toggles per read while busy
	always @(negedge pins.oe_n) if (busy && !pins.ce_n) tg = ~tg;
	// byte mode: line 15 picks the byte, upper lines read 8'h5A
	always @* begin
		if (busy) val = {8'h5A, ~mem[ix][7], tg, 6'h00};
		else if (!pins.byte_n) val = {8'h5A, bus[15] ? mem[ix][15:8] : mem[ix][7:0]};
		else val = mem[ix];
	end
	always @* if (drv) lastv = val;
	// released lines never keep the last value
	assign dev_q = drv ? val : ~lastv;
	assign ready_busy_n = !busy;
endmodule : bsf_flash_model
`default_nettype wire

/* bsf_host_ctrl_bench.sv */
`timescale 1ns/10ps
`default_nettype none
`include "bsf_defines.svh"
module bsf_host_ctrl_bench;
	import bsf_pkg::*;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, rb_n, clk_en;
	logic awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [1:0] bresp, rresp, rs, bs;
	bsf_pins_t fp;
	logic [15:0] dev_q, bus;
	int n_wr, n_fail, cmp_count, cyc, bad_oe, n0, k;
	assign bus = (fp.data_lines_oe & fp.data_lines_o) | (~fp.data_lines_oe & dev_q);
	bsf_host_ctrl dut(.aclk(aclk), .aresetn(aresetn), .ce(clk_en), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .flash_pins(fp),
		.data_lines_i(bus), .ready_busy_n(rb_n));
	bsf_flash_model #(.PROT_SECT(6)) model(.pins(fp), .bus(bus), .dev_q(dev_q),
		.ready_busy_n(rb_n), .n_wr(n_wr));
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	// generous ceiling: a few thousand cycles of traffic expected
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 60000) begin
			n_fail++;
			end_of_test();
		end
	end
	// host never drives lines 14..0 while the device outputs
	always @(negedge aclk) if (aresetn && !fp.oe_n && |fp.data_lines_oe[14:0]) bad_oe++;
	// ----------------------------------------
	// bus tasks
	// ----------------------------------------
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task axw(input logic [7:0] a, input logic [31:0] d);
		logic ra, rw, bv;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge aclk);
			ra = awready & awvalid;
			rw = wready & wvalid;
			bv = bvalid;
			bs = bresp;
			@(posedge aclk);
			if (ra) awvalid <= 1'b0;
			if (rw) wvalid <= 1'b0;
		end while (!bv);
	endtask : axw
	task axr(input logic [7:0] a);
		logic ra, rv;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge aclk);
			ra = arready & arvalid;
			rv = rvalid;
			rd = rdata;
			rs = rresp;
			@(posedge aclk);
			if (ra) arvalid <= 1'b0;
		end while (!rv);
	endtask : axr
	// back in idle state once busy clears
	task idle();
		do axr(`BSF_REG_STATUS); while (rd[0] !== 1'b0);
	endtask : idle
	task op(input logic [3:0] cmd, input logic [31:0] a, input logic [31:0] d, input logic [31:0] m);
		axw(`BSF_REG_ADDR, a);
		axw(`BSF_REG_WDATA, d);
		axw(`BSF_REG_CTRL, m | 32'h10 | {28'h0, cmd});
		idle();
	endtask : op
	task rdf(input logic [31:0] a, input logic [31:0] m);
		op(4'h0, a, 32'h0, m);
		axr(`BSF_REG_RDATA);
	endtask : rdf
	task end_of_test();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : end_of_test
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{awaddr, araddr, wdata} = 48'h0;
		clk_en = 1'b1;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		chk({fp.ce_n, fp.oe_n, fp.we_n, fp.rst_n, fp.byte_n}, 5'h1F);
		chk(fp.data_lines_oe, 16'h0000);
		@(posedge aclk);
		axr(8'h20);
		chk(rs, 2'h2);
		axw(8'h20, 32'h0);
		chk(bs, 2'h2);
		axr(`BSF_REG_CTRL);
		chk(rd, 32'h0);
		n0 = n_wr;
		op(4'h6, 32'h0, 32'h0, 32'h0);
		chk(n_wr - n0, 1);
		n0 = n_wr;
		op(4'h1, 32'h10, 32'h1234, 32'h0);
		chk(bs, 2'h0);
		chk(n_wr - n0, 4);
		rdf(32'h10, 32'h0);
		chk(rd, 32'h1234);
		op(4'h1, 32'h10, 32'hFF00, 32'h0);
		rdf(32'h10, 32'h0);
		chk(rd, 32'h1200);
		op(4'h7, 32'h0, 32'h0, 32'h0);
		axr(`BSF_REG_STATUS);
		chk(rd[1], 1'b1);
		n0 = n_wr;
		op(4'h1, 32'h8021, 32'h00F0, 32'h0);
		chk(n_wr - n0, 2);
		op(4'h8, 32'h0, 32'h0, 32'h0);
		axr(`BSF_REG_STATUS);
		chk(rd[1], 1'b0);
		op(4'h3, 32'h10, 32'h0, 32'h0);
		rdf(32'h10, 32'h0);
		chk(rd, 32'hFFFF);
		rdf(32'h8021, 32'h0);
		chk(rd, 32'h00F0);
		op(4'h1, 32'h30005, 32'h0, 32'h0);
		rdf(32'h30005, 32'h0);
		chk(rd, 32'hFFFF);
		// suspend is only honoured once polling has begun
		axw(`BSF_REG_CTRL, 32'h13);
		do axr(`BSF_REG_STATUS); while (rd[3] !== 1'b1);
		n0 = n_wr;
		axw(`BSF_REG_CTRL, 32'h14);
		idle();
		chk(n_wr - n0, 1);
		op(4'h1, 32'h8022, 32'h0F0F, 32'h0);
		rdf(32'h8022, 32'h0);
		chk(rd, 32'h0F0F);
		op(4'h5, 32'h0, 32'h0, 32'h0);
		// resumed erase shows up on the synchronised ready pin
		do axr(`BSF_REG_STATUS); while (rd[2] !== 1'b0);
		do axr(`BSF_REG_STATUS); while (rd[2] !== 1'b1);
		chk(rb_n, 1'b1);
		op(4'h2, 32'h0, 32'h0, 32'h0);
		rdf(32'h8021, 32'h0);
		chk(rd, 32'hFFFF);
		rdf(32'h21, 32'h100);
		chk(rd, 32'h00FF);
		chk(fp.byte_n, 1'b0);
		chk(fp.data_lines_oe, 16'h8000);
		axw(`BSF_REG_CTRL, 32'h200);
		repeat (3) @(posedge aclk);
		chk(fp.ce_n, 1'b1);
		axw(`BSF_REG_CTRL, 32'h12);
		do axr(`BSF_REG_STATUS); while (rd[3] !== 1'b1);
		k = 0;
		// five frozen cycles stretch the reset pulse from 11 to 16
		fork
			axw(`BSF_REG_CTRL, 32'h400);
			repeat (30) @(negedge aclk) if (fp.rst_n === 1'b0) k++;
			begin
				repeat (4) @(posedge aclk);
				clk_en <= 1'b0;
				repeat (5) @(posedge aclk);
				clk_en <= 1'b1;
			end
		join
		chk(k, 16);
		idle();
		axr(`BSF_REG_STATUS);
		chk(rd[2:0], 3'b100);
		chk(rb_n, 1'b1);
		chk(bad_oe, 0);
		end_of_test();
	end
endmodule : bsf_host_ctrl_bench
`default_nettype wire
